/* verilog/grip_pkg.sv */
// Purpose: shared constants and types of the gripper serial slave
// Assumes: 10 MHz system clock, 8N1 serial framing
// Notes: byte indices within six-byte blocks
package grip_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_DEFAULT = 115_200;
   localparam logic [15:0] BIT_CYCLES_DEFAULT = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
   localparam int CHAR_BITS = 10;
   // 3.5 chars in bit times
   localparam int GAP_BIT_TIMES = CHAR_BITS * 35 / 10;
   localparam int COMM_LOSS_MS = 1000;
   localparam int COMM_LOSS_CYCLES = CLK_HZ / 1000 * COMM_LOSS_MS;
   localparam logic [7:0] SLAVE_ADDR_DEFAULT = 8'h09;
   localparam logic [15:0] CMD_BASE = 16'h03e8;
   localparam logic [15:0] STAT_BASE = 16'h07d0;
   localparam logic [15:0] BLOCK_WORDS = 16'h0003;
   localparam int BLOCK_BYTES = 6;
   localparam int FRAME_MAX = 24;
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] FC_READ_WRITE = 8'h17;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [1:0] OBJ_MOVING = 2'h0;
   localparam logic [1:0] OBJ_STOP_OPEN = 2'h1;
   localparam logic [1:0] OBJ_STOP_CLOSE = 2'h2;
   localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
   localparam logic [1:0] STA_ACTIVE = 2'h3;
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [7:0] FAULT_COMM_LOSS = 8'h09;
   localparam logic [7:0] FORCE_LOW_MAX = 8'h7f;
   localparam int ACT_BIT = 0;
   localparam int GOTO_BIT = 3;
   localparam int BYTE_ACTION = 0;
   localparam int BYTE_POSITION = 3;
   localparam int BYTE_SPEED = 4;
   localparam int BYTE_FORCE = 5;
   typedef enum logic [2:0] {
      L_RECV = 3'b000, L_CHECK = 3'b001, L_EXEC = 3'b010, L_SEND = 3'b011, L_SENDW = 3'b100
   } link_e;
   typedef enum logic [2:0] {
      G_IDLE = 3'b000, G_MOVE = 3'b001, G_HOLD = 3'b010, G_REGRASP = 3'b011, G_AT = 3'b100
   } grip_e;
   typedef enum logic [1:0] {
      U_IDLE = 2'b00, U_START = 2'b01, U_DATA = 2'b10, U_STOP = 2'b11
   } rx_e;
endpackage

/* verilog/uart_link_if.sv */
// Purpose: byte link between frame logic and the serial line unit
// Assumes: one clock domain
// Notes: txStart is taken while txBusy is low
`timescale 1ns/1ns
interface uart_link_if;
   logic [15:0] bitCycles; // Clocks per bit
   logic [7:0] rxData; // Received byte
   logic rxStrobe; // One-cycle byte-valid pulse
   logic rxBusy; // Character in progress
   logic [7:0] txData; // Byte to send
   logic txStart; // Send request
   logic txBusy; // Sender occupied
   modport core(output bitCycles, txData, txStart, input rxData, rxStrobe, rxBusy, txBusy);
   modport phy(input bitCycles, txData, txStart, output rxData, rxStrobe, rxBusy, txBusy);
endinterface

/* verilog/rs485_uart.sv */
// Purpose: 8N1 receiver and transmitter for the serial line
// Assumes: rxd synchronous to clk_sys
// Notes: bit time set at run time through the link
`timescale 1ns/1ns
module rs485_uart
   import grip_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic ce,
   uart_link_if.phy link,
   input wire logic rxd,
   output logic txd
);
   typedef struct packed {
      rx_e rxPhase;
      logic [15:0] rxCnt;
      logic [2:0] rxBit;
      logic [7:0] rxShift;
      logic [7:0] rxData;
      logic rxStrobe;
      logic [15:0] txCnt;
      logic [3:0] txBits;
      logic [8:0] txShift;
      logic txBusy;
      logic txd;
   } uart_s;
   uart_s s; // Current state
   uart_s next_s; // Next state

   // Receive and transmit sequencing
   always_comb begin
      next_s = s;
      next_s.rxStrobe = 1'b0;
      if (s.rxCnt != 16'h0000) begin
         next_s.rxCnt = s.rxCnt - 16'h0001;
      end
      case (s.rxPhase)
         U_IDLE: begin
            // Start edge, sample mid start bit
            if (!rxd) begin
               next_s.rxPhase = U_START;
               next_s.rxCnt = link.bitCycles >> 1;
            end
         end
         U_START: begin
            if (s.rxCnt == 16'h0000) begin
               next_s.rxPhase = rxd ? U_IDLE : U_DATA;
               next_s.rxCnt = link.bitCycles - 16'h0001;
               next_s.rxBit = 3'h0;
            end
         end
         U_DATA: begin
            // Least significant bit arrives first
            if (s.rxCnt == 16'h0000) begin
               next_s.rxShift = {rxd, s.rxShift[7:1]};
               next_s.rxBit = s.rxBit + 3'h1;
               next_s.rxCnt = link.bitCycles - 16'h0001;
               if (s.rxBit == 3'h7) begin
                  next_s.rxPhase = U_STOP;
               end
            end
         end
         U_STOP: begin
            // A low stop bit drops the byte
            if (s.rxCnt == 16'h0000) begin
               next_s.rxPhase = U_IDLE;
               next_s.rxData = s.rxShift;
               next_s.rxStrobe = rxd;
            end
         end
         default: next_s.rxPhase = U_IDLE;
      endcase
      // Transmit start, 8 data, stop
      if (!s.txBusy) begin
         if (link.txStart) begin
            next_s.txBusy = 1'b1;
            next_s.txd = 1'b0;
            next_s.txShift = {1'b1, link.txData};
            next_s.txBits = 4'h9;
            next_s.txCnt = link.bitCycles - 16'h0001;
         end
      end else if (s.txCnt != 16'h0000) begin
         next_s.txCnt = s.txCnt - 16'h0001;
      end else if (s.txBits == 4'h0) begin
         next_s.txBusy = 1'b0;
         next_s.txd = 1'b1;
      end else begin
         next_s.txd = s.txShift[0];
         next_s.txShift = {1'b1, s.txShift[8:1]};
         next_s.txBits = s.txBits - 4'h1;
         next_s.txCnt = link.bitCycles - 16'h0001;
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.txd <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign link.rxData = s.rxData;
   assign link.rxStrobe = s.rxStrobe;
   assign link.rxBusy = s.rxPhase != U_IDLE;
   assign link.txBusy = s.txBusy;
   assign txd = s.txd;
endmodule

/* verilog/grip_modbus_slave.sv */
// Purpose: serial command slave and grasp sequencing of a gripper
// Assumes: inputs synchronous to clk_sys; one master on the line
// Notes: bad frames are dropped silently, never answered
`timescale 1ns/1ns
// Notes on behaviour
// - Force zero: lowest force, re-grasp off
// - Force 1 to 127: low torque, re-grasp on
// - Force 128 to 255: high torque, re-grasp on
// - Slip after a closing contact stop while re-grasp on: close again
// - Re-grasp stops at stored target
// - Re-grasp uses reduced force and speed
// - Motion clears object state to moving
// - Report 0 moving, 3 at target
// - Report 1 opening contact, 2 closing contact
// - Line 115200 baud, 8N1 by default
// - Only codes 3, 4, 16, 23; no exceptions
// - Slave address 9, address and rate configurable
// - Command block 0x3e8, status block 0x7d0
// - Two internal bytes per register
// - Addresses high byte first, data low first
// - Goto starts motion with requested settings
// - One second silence reports fault 9
module grip_modbus_slave
   import grip_pkg::*;
#(
   parameter int COMM_LOSS_LIMIT = COMM_LOSS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic rxd,
   output logic txd,
   output logic txEn,
   input wire logic cfgLoad,
   input wire logic [7:0] cfgSlaveAddr,
   input wire logic [15:0] cfgBitCycles,
   input wire logic [7:0] fingerPos,
   input wire logic [7:0] motorCurrent,
   input wire logic contactStop,
   input wire logic motionSeen,
   input wire logic slipSeen,
   output logic motorRun,
   output logic [7:0] motorTarget,
   output logic [7:0] motorSpeed,
   output logic [7:0] motorForce,
   output logic torqueHigh,
   output logic regraspOn,
   output logic lowestForce
);
   typedef struct packed {
      link_e link;
      logic [FRAME_MAX-1:0][7:0] frame;
      logic [4:0] count;
      logic overflow;
      logic [4:0] idx;
      logic [21:0] gap;
      logic [15:0] crc;
      logic [4:0] respLen;
      logic [7:0] slaveAddr;
      logic [15:0] bitCycles;
      logic [BLOCK_BYTES-1:0][7:0] cmd;
      logic kick;
      logic [23:0] commTimer;
      logic commLost;
      logic txStart;
      logic [7:0] txData;
      logic txEn;
      grip_e grip;
      logic [1:0] obj;
      logic closing;
      logic motorRun;
      logic [7:0] motorTarget;
      logic [7:0] motorSpeed;
      logic [7:0] motorForce;
      logic torqueHigh;
      logic regraspOn;
      logic lowestForce;
   } core_s;
   core_s s; // Current state
   core_s next_s; // Next state
   uart_link_if link (); // Byte link to the line unit

   // Modbus CRC-16, reflected, one byte
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Serial line unit
   rs485_uart uart (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ce(ce),
      .link(link.core),
      .rxd(rxd),
      .txd(txd)
   );

   // Frame handling and grasp sequencing
   always_comb begin
      logic [7:0] fc; // Function code
      logic [15:0] rdAddr; // Read base
      logic [15:0] rdCnt; // Read count
      logic [15:0] wrAddr; // Write base
      logic [15:0] wrCnt; // Write count
      logic [7:0] bc; // Byte count
      logic [4:0] dataOff; // Data offset
      logic rdOk; // Read ok
      logic wrOk; // Write ok
      logic frameOk; // Shape ok
      logic [2:0] rdStart; // Read word
      logic [2:0] wrStart; // Write word
      logic [21:0] gapLimit; // Silence limit
      logic [7:0] b; // Sent byte
      logic [BLOCK_BYTES-1:0][7:0] stat; // Status bytes
      next_s = s;
      next_s.txStart = 1'b0;
      next_s.kick = 1'b0;
      fc = s.frame[1];
      rdAddr = {s.frame[2], s.frame[3]};
      rdCnt = {s.frame[4], s.frame[5]};
      wrAddr = rdAddr;
      wrCnt = rdCnt;
      bc = s.frame[6];
      dataOff = 5'd7;
      if (fc == FC_READ_WRITE) begin
         wrAddr = {s.frame[6], s.frame[7]};
         wrCnt = {s.frame[8], s.frame[9]};
         bc = s.frame[10];
         dataOff = 5'd11;
      end
      rdOk = rdAddr >= STAT_BASE && rdCnt != 16'h0000 && rdCnt <= BLOCK_WORDS
         && rdAddr - STAT_BASE <= BLOCK_WORDS - rdCnt;
      wrOk = wrAddr >= CMD_BASE && wrCnt != 16'h0000 && wrCnt <= BLOCK_WORDS
         && wrAddr - CMD_BASE <= BLOCK_WORDS - wrCnt && {8'h00, bc} == wrCnt << 1;
      rdStart = 3'(rdAddr - STAT_BASE);
      wrStart = 3'(wrAddr - CMD_BASE);
      case (fc)
         FC_READ_HOLD, FC_READ_INPUT: frameOk = rdOk && s.count == 5'd8;
         FC_WRITE_MULTI: frameOk = wrOk && s.count == 5'd9 + bc[4:0];
         FC_READ_WRITE: frameOk = rdOk && wrOk && s.count == 5'd13 + bc[4:0];
         default: frameOk = 1'b0;
      endcase
      gapLimit = 22'({6'h00, s.bitCycles} * 22'(GAP_BIT_TIMES));
      stat[0] = {s.obj, s.cmd[BYTE_ACTION][ACT_BIT] ? STA_ACTIVE : 2'h0,
                 s.cmd[BYTE_ACTION][GOTO_BIT], 2'h0, s.cmd[BYTE_ACTION][ACT_BIT]};
      stat[1] = 8'h00;
      stat[2] = s.commLost ? FAULT_COMM_LOSS : FAULT_NONE;
      stat[3] = s.cmd[BYTE_POSITION];
      stat[4] = fingerPos;
      stat[5] = motorCurrent;
      b = 8'h00;
      // Run-time slave address and bit rate
      if (cfgLoad) begin
         next_s.slaveAddr = cfgSlaveAddr;
         next_s.bitCycles = cfgBitCycles;
      end
      // Silence watchdog, restarted by each good frame
      if (!s.commLost) begin
         next_s.commTimer = s.commTimer + 24'h000001;
         if (s.commTimer == 24'(COMM_LOSS_LIMIT - 1)) begin
            next_s.commLost = 1'b1;
         end
      end
      // Frame sequencing
      case (s.link)
         L_RECV: begin
            // Collect bytes, too many marks overflow
            if (link.rxStrobe) begin
               next_s.gap = 22'h000000;
               if (s.count < 5'(FRAME_MAX)) begin
                  next_s.frame[s.count] = link.rxData;
                  next_s.count = s.count + 5'd1;
               end else begin
                  next_s.overflow = 1'b1;
               end
            end else if (link.rxBusy || s.count == 5'd0) begin
               next_s.gap = 22'h000000;
            end else if (s.gap >= gapLimit) begin
               next_s.link = L_CHECK;
               next_s.idx = 5'd0;
               next_s.crc = CRC_INIT;
            end else begin
               next_s.gap = s.gap + 22'h000001;
            end
         end
         L_CHECK: begin
            // CRC over frame and its check word
            if (s.idx < s.count) begin
               next_s.crc = crcByte(s.crc, s.frame[s.idx]);
               next_s.idx = s.idx + 5'd1;
            end else if (s.crc == 16'h0000 && !s.overflow && frameOk
                         && s.frame[0] == s.slaveAddr) begin
               next_s.link = L_EXEC;
            end else begin
               // Drop silently, no answer
               next_s.link = L_RECV;
               next_s.count = 5'd0;
               next_s.overflow = 1'b0;
               next_s.gap = 22'h000000;
            end
         end
         L_EXEC: begin
            // Data low byte first, lower byte leads
            if (fc == FC_WRITE_MULTI || fc == FC_READ_WRITE) begin
               for (int j = 0; j < BLOCK_BYTES; j++) begin
                  if (j >= 2 * wrStart && j < 2 * wrStart + bc) begin
                     next_s.cmd[j] = s.frame[5'(dataOff + j - 2 * wrStart)];
                  end
               end
               next_s.kick = 1'b1;
            end
            next_s.respLen = fc == FC_WRITE_MULTI ? 5'd8 : 5'(5 + 2 * rdCnt[2:0]);
            next_s.idx = 5'd0;
            next_s.crc = CRC_INIT;
            next_s.txEn = 1'b1;
            next_s.link = L_SEND;
         end
         L_SEND: begin
            if (s.idx == s.respLen) begin
               // Fault stays visible in this answer, cleared after it
               next_s.commTimer = 24'h000000;
               next_s.commLost = 1'b0;
               next_s.txEn = 1'b0;
               next_s.link = L_RECV;
               next_s.count = 5'd0;
               next_s.gap = 22'h000000;
            end else begin
               if (s.idx == s.respLen - 5'd2) begin
                  b = s.crc[7:0];
               end else if (s.idx == s.respLen - 5'd1) begin
                  b = s.crc[15:8];
               end else begin
                  if (s.idx == 5'd0) begin
                     b = s.slaveAddr;
                  end else if (s.idx == 5'd1) begin
                     b = fc;
                  end else if (fc == FC_WRITE_MULTI) begin
                     b = s.frame[s.idx];
                  end else if (s.idx == 5'd2) begin
                     b = {4'h0, rdCnt[2:0], 1'b0};
                  end else begin
                     b = stat[3'({rdStart, 1'b0} + 4'(s.idx - 5'd3))];
                  end
                  next_s.crc = crcByte(s.crc, b);
               end
               next_s.txData = b;
               next_s.txStart = 1'b1;
               next_s.idx = s.idx + 5'd1;
               next_s.link = L_SENDW;
            end
         end
         L_SENDW: begin
            // Wait for the byte to leave
            if (!s.txStart && !link.txBusy) begin
               next_s.link = L_SEND;
            end
         end
         default: next_s.link = L_RECV;
      endcase
      // Zero force: lowest force, no re-grasp
      next_s.lowestForce = s.cmd[BYTE_FORCE] == 8'h00;
      next_s.regraspOn = s.cmd[BYTE_FORCE] != 8'h00;
      next_s.torqueHigh = s.cmd[BYTE_FORCE] > FORCE_LOW_MAX;
      if (motionSeen) begin
         next_s.obj = OBJ_MOVING;
      end
      // Grasp sequencing
      case (s.grip)
         G_IDLE: next_s.motorRun = 1'b0;
         G_MOVE, G_REGRASP: begin
            if (fingerPos == s.motorTarget) begin
               next_s.grip = G_AT;
               next_s.obj = OBJ_AT_TARGET;
               next_s.motorRun = 1'b0;
            end else if (contactStop) begin
               next_s.grip = G_HOLD;
               next_s.obj = s.closing ? OBJ_STOP_CLOSE : OBJ_STOP_OPEN;
               next_s.motorRun = 1'b0;
            end
         end
         G_HOLD: begin
            if (slipSeen && s.regraspOn && s.closing) begin
               next_s.grip = G_REGRASP;
               next_s.motorRun = 1'b1;
               next_s.motorTarget = s.cmd[BYTE_POSITION];
               next_s.motorSpeed = s.cmd[BYTE_SPEED] >> 1;
               next_s.motorForce = s.cmd[BYTE_FORCE] >> 1;
            end else if (slipSeen) begin
               next_s.grip = G_AT;
               next_s.obj = OBJ_AT_TARGET;
            end
         end
         G_AT: next_s.motorRun = 1'b0;
         default: next_s.grip = G_IDLE;
      endcase
      if (!s.cmd[BYTE_ACTION][GOTO_BIT] || !s.cmd[BYTE_ACTION][ACT_BIT]) begin
         next_s.grip = G_IDLE;
         next_s.motorRun = 1'b0;
      end else if (s.kick) begin
         next_s.grip = G_MOVE;
         next_s.motorRun = 1'b1;
         next_s.motorTarget = s.cmd[BYTE_POSITION];
         next_s.motorSpeed = s.cmd[BYTE_SPEED];
         next_s.motorForce = s.cmd[BYTE_FORCE];
         next_s.closing = s.cmd[BYTE_POSITION] > fingerPos;
         next_s.obj = OBJ_MOVING;
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.slaveAddr <= SLAVE_ADDR_DEFAULT;
         s.bitCycles <= BIT_CYCLES_DEFAULT;
         s.lowestForce <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Outputs straight from state flops
   assign link.bitCycles = s.bitCycles;
   assign link.txData = s.txData;
   assign link.txStart = s.txStart;
   assign txEn = s.txEn;
   assign motorRun = s.motorRun;
   assign motorTarget = s.motorTarget;
   assign motorSpeed = s.motorSpeed;
   assign motorForce = s.motorForce;
   assign torqueHigh = s.torqueHigh;
   assign regraspOn = s.regraspOn;
   assign lowestForce = s.lowestForce;
endmodule

/* tb/grip_modbus_slave_asserts.sv */
// Purpose: port checks of gripper slave
// Assumes: one clock, async active-high reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module grip_modbus_slave_asserts (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rxd,
   input wire logic txd,
   input wire logic txEn,
   input wire logic slipSeen,
   input wire logic motorRun,
   input wire logic torqueHigh,
   input wire logic regraspOn,
   input wire logic lowestForce
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   property p_zero;
      lowestForce != regraspOn;
   endproperty
   a_zero: assert property (p_zero) else $error("zero mode");
   property p_high;
      torqueHigh |-> regraspOn;
   endproperty
   a_high: assert property (p_high) else $error("high no regrasp");
   property p_idle;
      !txEn |-> txd;
   endproperty
   a_idle: assert property (p_idle) else $error("txd low idle");
   property p_quiet;
      $rose(txEn) |-> $past(rxd);
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer during activity");
   property p_start;
      $rose(txEn) |-> txd ##[1:3] !txd;
   endproperty
   a_start: assert property (p_start) else $error("late start bit");
   property p_hold;
      $rose(txEn) |-> txEn [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("enable short");
   property p_mode;
      $changed(regraspOn) || $changed(torqueHigh) |-> txEn;
   endproperty
   a_mode: assert property (p_mode) else $error("mode change");
   property p_run;
      $rose(motorRun) && !($past(slipSeen) || $past(slipSeen, 2) || $past(slipSeen, 3)) |-> txEn;
   endproperty
   a_run: assert property (p_run) else $error("stray motion");
endmodule

/* tb/modbus_master_model.sv */
// Purpose: serial bus master
// Assumes: 8N1 framing, bit time of BIT_CLKS clocks
// Notes: adds checksum, keeps answer
`timescale 1ns/1ns
module modbus_master_model #(
   parameter int BIT_CLKS = 8
) (
   input wire logic clk_sys,
   output logic rxd,
   input wire logic txd,
   input wire logic txEn
);
   logic [7:0] reply[$]; // Last answer
   initial rxd = 1'b1;
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction
   task automatic sendBit(input logic v);
      @(posedge clk_sys);
      rxd <= v;
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
   endtask
   task automatic sendFrame(input logic [7:0] q[$], input logic spoil);
      logic [7:0] f[$];
      logic [15:0] c;
      f = q;
      c = crc16(q) ^ {15'h0000, spoil};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         sendBit(1'b0);
         for (int b = 0; b < 8; b++) begin
            sendBit(f[i][b]);
         end
         sendBit(1'b1);
      end
   endtask
   // Bounded wait, bytes sampled mid-bit
   task automatic getReply(input int waitMax);
      int n;
      logic [7:0] d;
      reply.delete();
      n = 0;
      while (!txEn && n < waitMax) begin
         @(negedge clk_sys);
         n++;
      end
      for (int k = 0; k < 30 && txEn; k++) begin
         n = 0;
         while (txd && txEn && n < 40) begin
            @(negedge clk_sys);
            n++;
         end
         if (txd) begin
            break;
         end
         repeat (BIT_CLKS / 2) @(negedge clk_sys);
         for (int b = 0; b < 9; b++) begin
            repeat (BIT_CLKS) @(negedge clk_sys);
            if (b < 8) begin
               d[b] = txd;
            end
         end
         reply.push_back(d);
      end
   endtask
endmodule

/* tb/grip_modbus_slave_tb_top.sv */
// Purpose: bench of gripper slave
// Assumes: 8-clock bit time, short comm-loss limit
// Notes: model drives rxd, collects answers
`timescale 1ns/1ns
module grip_modbus_slave_tb_top
   import grip_pkg::*;
;
   logic clk_sys, sys_rst, ce, rxd, txd, txEn, cfgLoad, contactStop, motionSeen, slipSeen;
   logic motorRun, torqueHigh, regraspOn, lowestForce;
   logic [7:0] cfgSlaveAddr, fingerPos, motorCurrent, motorTarget, motorSpeed, motorForce;
   logic [15:0] cfgBitCycles;
   logic [7:0] rsp[$]; // Last answer
   int failures, checked;
   grip_modbus_slave #(.COMM_LOSS_LIMIT(20000)) grip_modbus_slave_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .ce(ce), .rxd(rxd), .txd(txd), .txEn(txEn), .cfgLoad(cfgLoad),
      .cfgSlaveAddr(cfgSlaveAddr), .cfgBitCycles(cfgBitCycles), .fingerPos(fingerPos),
      .motorCurrent(motorCurrent), .contactStop(contactStop), .motionSeen(motionSeen),
      .slipSeen(slipSeen), .motorRun(motorRun), .motorTarget(motorTarget),
      .motorSpeed(motorSpeed), .motorForce(motorForce), .torqueHigh(torqueHigh),
      .regraspOn(regraspOn), .lowestForce(lowestForce));
   modbus_master_model modbus_master_model_inst (.clk_sys(clk_sys), .rxd(rxd), .txd(txd),
      .txEn(txEn));
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("Checks made %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // next request only after the answer
   task automatic xact(input logic [7:0] q[$], input logic spoil, input int len);
      logic [15:0] c;
      modbus_master_model_inst.sendFrame(q, spoil);
      modbus_master_model_inst.getReply(600);
      rsp = modbus_master_model_inst.reply;
      c = modbus_master_model_inst.crc16(rsp);
      cmp("reply length", 8'(len), 8'(rsp.size()));
      if (len > 0 && rsp.size() == 0) begin
         close_out();
      end
      if (len > 0) begin
         cmp("reply crc", 8'h00, c[15:8] | c[7:0]);
         cmp("reply fc", q[1], rsp[1]);
      end
   endtask
   task automatic wr(input logic [7:0] act, pos, spd, frc);
      xact('{8'h09, FC_WRITE_MULTI, 8'h03, 8'he8, 8'h00, 8'h03, 8'h06, act, 8'h00, 8'h00,
         pos, spd, frc}, 1'b0, 8);
      cmp("echo", 8'he8, rsp[3]);
   endtask
   task automatic rd(input logic [7:0] fc);
      xact('{8'h09, fc, 8'h07, 8'hd0, 8'h00, 8'h03}, 1'b0, 11);
      cmp("byte count", 8'h06, rsp[2]);
   endtask
   task automatic settle();
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic s_reset();
      cmp("rst force", 8'h01, 8'(lowestForce));
      cmp("reset motor", 8'h00, 8'(motorRun));
   endtask
   task automatic s_read();
      wr(8'h00, 8'h33, 8'h00, 8'h00);
      rd(FC_READ_HOLD);
      cmp("pos echo", 8'h33, rsp[6]);
      rd(FC_READ_INPUT);
      cmp("finger pos", 8'h10, rsp[7]);
      cmp("current", 8'ha5, rsp[8]);
   endtask
   task automatic s_force();
      logic [7:0] f[5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
      foreach (f[i]) begin
         wr(8'h00, 8'h00, 8'h00, f[i]);
         cmp("lowest", 8'(f[i] == 8'h00), 8'(lowestForce));
         cmp("regrasp on", 8'(f[i] != 8'h00), 8'(regraspOn));
         cmp("high torque", 8'(f[i] > 8'h7f), 8'(torqueHigh));
      end
   endtask
   task automatic s_refuse();
      xact('{8'h09, FC_READ_HOLD, 8'h07, 8'hd0, 8'h00, 8'h03}, 1'b1, 0);
      xact('{8'h0a, FC_WRITE_MULTI, 8'h03, 8'he8, 8'h00, 8'h03, 8'h06, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00}, 1'b0, 0);
      xact('{8'h09, 8'h05, 8'h03, 8'he8, 8'hff, 8'h00}, 1'b0, 0);
      cmp("force kept", 8'h00, 8'(lowestForce));
   endtask
   // object state read with goto set
   task automatic s_grasp();
      xact('{8'h09, FC_READ_WRITE, 8'h07, 8'hd0, 8'h00, 8'h03, 8'h03, 8'he8, 8'h00, 8'h03,
         8'h06, 8'h09, 8'h00, 8'h00, 8'h80, 8'h40, 8'hc8}, 1'b0, 11);
      cmp("goto run", 8'h01, 8'(motorRun));
      cmp("motor force", 8'hc8, motorForce);
      @(posedge clk_sys);
      contactStop <= 1'b1;
      settle();
      rd(FC_READ_HOLD);
      cmp("obj close", {OBJ_STOP_CLOSE, STA_ACTIVE, 4'h9}, rsp[3]);
      @(posedge clk_sys);
      contactStop <= 1'b0;
      slipSeen <= 1'b1;
      @(posedge clk_sys);
      slipSeen <= 1'b0;
      settle();
      cmp("rg run", 8'h01, 8'(motorRun));
      cmp("rg force", 8'h01, 8'(motorForce <= 8'hc8));
      cmp("rg speed", 8'h01, 8'(motorSpeed <= 8'h40));
      @(posedge clk_sys);
      fingerPos <= 8'h80;
      settle();
      cmp("at target", 8'h00, 8'(motorRun));
      rd(FC_READ_HOLD);
      cmp("obj lost", {OBJ_AT_TARGET, STA_ACTIVE, 4'h9}, rsp[3]);
      @(posedge clk_sys);
      motionSeen <= 1'b1;
      rd(FC_READ_HOLD);
      cmp("obj moving", {OBJ_MOVING, STA_ACTIVE, 4'h9}, rsp[3]);
      @(posedge clk_sys);
      motionSeen <= 1'b0;
      wr(8'h09, 8'h00, 8'h40, 8'h10);
      @(posedge clk_sys);
      contactStop <= 1'b1;
      rd(FC_READ_HOLD);
      cmp("obj open", {OBJ_STOP_OPEN, STA_ACTIVE, 4'h9}, rsp[3]);
   endtask
   task automatic s_loss();
      repeat (20100) @(posedge clk_sys);
      rd(FC_READ_HOLD);
      cmp("comm loss", 8'h09, rsp[5]);
      rd(FC_READ_HOLD);
      cmp("fault clear", 8'h00, rsp[5]);
   endtask
   // Free-running clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Main sequence
   initial begin
      failures = 0;
      checked = 0;
      sys_rst = 1'b1;
      ce = 1'b1;
      cfgLoad = 1'b0;
      cfgSlaveAddr = 8'h09;
      cfgBitCycles = 16'h0008;
      fingerPos = 8'h10;
      motorCurrent = 8'ha5;
      contactStop = 1'b0;
      motionSeen = 1'b0;
      slipSeen = 1'b0;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      s_reset();
      @(posedge clk_sys);
      cfgLoad <= 1'b1;
      @(posedge clk_sys);
      cfgLoad <= 1'b0;
      s_read();
      s_force();
      s_refuse();
      s_grasp();
      s_loss();
      close_out();
   end
   // Hang guard
   initial begin
      repeat (95000) @(posedge clk_sys);
      failures++;
      close_out();
   end
endmodule
bind grip_modbus_slave grip_modbus_slave_asserts grip_modbus_slave_asserts_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .rxd(rxd), .txd(txd), .txEn(txEn),
   .slipSeen(slipSeen), .motorRun(motorRun), .torqueHigh(torqueHigh), .regraspOn(regraspOn),
   .lowestForce(lowestForce));
